/* File: pkg/gl_pkg.sv */
// Purpose: shared constants, types and helpers of the guard lock supervisor
// Assumes: 25 MHz system clock, APB register access
// Notes:   delays are kept in milliseconds and counted against a 1 ms tick
`default_nettype none
package gl_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_W        = 16;

	// release delay segments, in ms
	localparam logic [MS_W-1:0] UNL_STEP_A = 16'h0064;  // 100 ms
	localparam logic [MS_W-1:0] UNL_BASE_B = 16'h05DC;  // 1.5 s
	localparam logic [MS_W-1:0] UNL_STEP_B = 16'h01F4;  // 0.5 s
	localparam logic [MS_W-1:0] UNL_BASE_C = 16'h3A98;  // 15 s
	localparam logic [MS_W-1:0] UNL_STEP_C = 16'h1388;  // 5 s
	localparam logic [4:0]      UNL_IDX_B  = 5'h0B;
	localparam logic [4:0]      UNL_IDX_C  = 5'h1D;

	// feedback time segments, in ms
	localparam logic [MS_W-1:0] FBK_STEP_A = 16'h000A;  // 10 ms
	localparam logic [MS_W-1:0] FBK_BASE_B = 16'h0096;  // 150 ms
	localparam logic [MS_W-1:0] FBK_STEP_B = 16'h0032;  // 50 ms
	localparam logic [MS_W-1:0] FBK_BASE_C = 16'h05DC;  // 1.5 s
	localparam logic [MS_W-1:0] FBK_STEP_C = 16'h01F4;  // 0.5 s
	localparam logic [4:0]      FBK_IDX_B  = 5'h0A;
	localparam logic [4:0]      FBK_IDX_C  = 5'h1C;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int              ADDR_W       = 12;
	localparam logic [11:0]     ADDR_CTRL    = 12'h000;
	localparam logic [11:0]     ADDR_STATUS  = 12'h004;
	localparam logic [11:0]     ADDR_INT_ST  = 12'h008;
	localparam logic [11:0]     ADDR_INT_MSK = 12'h00C;
	localparam logic [14:0]     CTRL_RESET   = 15'h0000;
	localparam logic [2:0]      IRQ_RESET    = 3'h0;

	typedef enum logic [1:0] {
		GATE_PRESENT   = 2'h0,
		GATE_ABSENT    = 2'h1,
		GATE_MANDATORY = 2'h2,
		GATE_SPARE     = 2'h3
	} gl_gate_t;

	typedef struct packed {
		logic [4:0] fbkIdx;
		logic [4:0] unlockIdx;
		logic       spring;
		logic       errOutEn;
		logic       monitored;
		gl_gate_t   gateMode;
	} gl_ctrl_t;

	typedef struct packed {
		logic unlockedEv;
		logic lockedEv;
		logic faultEv;
	} gl_irq_t;

	typedef enum {
		GL_UNLOCKED,
		GL_LOCKING,
		GL_LOCKED,
		GL_RELEASE,
		GL_UNLOCKING,
		GL_OPENWAIT,
		GL_FAULT
	} gl_state_t;

	// ---------------------------------------------------------------
	// pin carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic unlockReq;
		logic lockFbk;
		logic gateFbk;
		logic resetIn;
	} gl_pin_in_t;

	typedef struct packed {
		logic mainOut;
		logic lockDrive;
		logic faultFlag;
	} gl_pin_out_t;

	// ---------------------------------------------------------------
	// delay tables
	// ---------------------------------------------------------------
	function automatic logic [MS_W-1:0] unlockMs(input logic [4:0] idx);
		logic [MS_W-1:0] i;
		i = {11'h000, idx};
		if (idx < UNL_IDX_B) begin
			unlockMs = 16'(i * UNL_STEP_A);
		end else if (idx < UNL_IDX_C) begin
			unlockMs = 16'(UNL_BASE_B + (i - 16'(UNL_IDX_B)) * UNL_STEP_B);
		end else begin
			unlockMs = 16'(UNL_BASE_C + (i - 16'(UNL_IDX_C)) * UNL_STEP_C);
		end
	endfunction

	function automatic logic [MS_W-1:0] fbkMs(input logic [4:0] idx);
		logic [MS_W-1:0] i;
		i = {11'h000, idx};
		if (idx < FBK_IDX_B) begin
			fbkMs = 16'((i + 16'h0001) * FBK_STEP_A);
		end else if (idx < FBK_IDX_C) begin
			fbkMs = 16'(FBK_BASE_B + (i - 16'(FBK_IDX_B)) * FBK_STEP_B);
		end else begin
			fbkMs = 16'(FBK_BASE_C + (i - 16'(FBK_IDX_C)) * FBK_STEP_C);
		end
	endfunction

endpackage
`default_nettype wire

/* File: hw/gl_timer.sv */
// Purpose: millisecond down timer with a cycle prescaler
// Assumes: load is a one-cycle pulse
// Notes:   done stays high once the count has run out, until the next load
`timescale 1ns/1ns
`default_nettype none
module gl_timer #(
	parameter int TICK_CYCLES = gl_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	// control
	input  wire logic                    load,
	input  wire logic [gl_pkg::MS_W-1:0] loadMs,
	// status
	output logic                         done
);
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [gl_pkg::MS_W-1:0] count;
		logic [PRE_W-1:0]        pre;
		logic                    running;
	} gl_tmr_t;

	gl_tmr_t s;
	gl_tmr_t next_s;

	always_comb begin
		next_s = s;
		if (load) begin
			next_s.count   = loadMs;
			next_s.pre     = '0;
			next_s.running = 1'b1;
		end else if (s.running && s.count != '0) begin
			if (s.pre == PRE_LAST) begin
				next_s.pre   = '0;
				next_s.count = s.count - 1'b1;
			end else begin
				next_s.pre = s.pre + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.running && (s.count == '0);
endmodule
`default_nettype wire

/* File: hw/gl_reset_detect.sv */
// Purpose: accepts a reset gesture on the reset input
// Assumes: resetIn is synchronous to sys_clk
// Notes:   accept is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module gl_reset_detect (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// gesture
	input  wire logic resetIn,
	input  wire logic monitored,
	output logic      accept
);
	typedef struct packed {
		logic prev;
		logic armed;
	} gl_rst_t;

	gl_rst_t s;
	gl_rst_t next_s;
	logic    rise;
	logic    fall;

	always_comb begin
		rise         = resetIn && !s.prev;
		fall         = !resetIn && s.prev;
		next_s.prev  = resetIn;
		next_s.armed = s.armed;
		if (rise) begin
			next_s.armed = 1'b1;
		end else if (fall) begin
			next_s.armed = 1'b0;
		end
		// manual: the rise alone; monitored: the rise and then the fall
		accept = monitored ? (fall && s.armed) : rise;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

/* File: hw/gl_supervisor.sv */
// Purpose: electromechanical guard lock supervisor with APB registers
// Assumes: lock, door and reset pins synchronous to sys_clk; lockFbk high = locked
// Notes:   gateFbk high = door closed; lockDrive high = coil energised
//
// Functional notes
// - main output high only while lock confirmed engaged and, unless gate absent, door closed.
// - unlock request drops main output at once; lock released after delay.
// - unlock request acted upon only in the locked state.
// - any fault forces main output low: door open, late feedback.
// - lock drive, lock feedback and door feedback checked for consistency.
// - mandatory opening mode waits for the door to open after unlock.
// - gate-absent mode supervises with lock feedback only, door ignored.
// - manual reset accepted on a single rising edge of reset input.
// - monitored reset accepted after rise and return low.
// - release delay 0-1 s by 100 ms, 1.5-10 s by 0.5 s, 15-25 s by 5 s.
// - feedback time in 10 ms, 50 ms, then 0.5 s steps to 3 s.
// - with fault output enabled, fault flag high on lock malfunction.
// - spring interlock option: coil energised to release, not to lock.
`timescale 1ns/1ns
`default_nettype none
module gl_supervisor #(
	parameter int TICK_CYCLES = gl_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_b,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [gl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// lock pins
	input  wire gl_pkg::gl_pin_in_t        pinIn,
	output gl_pkg::gl_pin_out_t            pinOut,
	// interrupt
	output logic                           irq
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		gl_pkg::gl_state_t state;
		logic              lockCmd;
		gl_pkg::gl_ctrl_t  ctrl;
		gl_pkg::gl_irq_t   irqStatus;
		gl_pkg::gl_irq_t   irqMask;
		logic [31:0]       rdata;
	} gl_sup_t;

	gl_sup_t                 s;
	gl_sup_t                 next_s;
	logic                    tmrLoad;
	logic [gl_pkg::MS_W-1:0] tmrMs;
	logic                    tmrDone;
	logic                    resetAccept;
	logic                    doorOk;
	logic                    lockFault;
	logic                    gateAbsent;
	logic                    apbSetup;
	logic                    apbAccess;
	logic                    apbWrite;
	logic                    addrKnown;
	gl_pkg::gl_irq_t         events;
	gl_pkg::gl_irq_t         w1c;

	function automatic logic knownAddr(input logic [gl_pkg::ADDR_W-1:0] a);
		knownAddr = (a == gl_pkg::ADDR_CTRL) || (a == gl_pkg::ADDR_STATUS) ||
			(a == gl_pkg::ADDR_INT_ST) || (a == gl_pkg::ADDR_INT_MSK);
	endfunction

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	gl_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (tmrLoad),
		.loadMs  (tmrMs),
		.done    (tmrDone)
	);

	gl_reset_detect u_reset (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.resetIn   (pinIn.resetIn),
		.monitored (s.ctrl.monitored),
		.accept    (resetAccept)
	);

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	assign apbSetup  = psel && !penable;
	assign apbAccess = psel && penable;
	assign addrKnown = knownAddr(paddr);
	assign apbWrite  = apbAccess && pwrite && addrKnown;
	// zero wait states; read data is captured in the setup cycle
	assign pready    = 1'b1;
	assign pslverr   = apbAccess && !addrKnown;
	assign prdata    = s.rdata;

	// ---------------------------------------------------------------
	// lock supervision
	// ---------------------------------------------------------------
	assign gateAbsent = (s.ctrl.gateMode == gl_pkg::GATE_ABSENT);
	// door feedback ignored when no gate is fitted
	assign doorOk     = gateAbsent || pinIn.gateFbk;
	// while locked, door and lock feedback must agree with the drive
	assign lockFault  = !doorOk || !pinIn.lockFbk;

	always_comb begin
		next_s  = s;
		tmrLoad = 1'b0;
		tmrMs   = gl_pkg::fbkMs(s.ctrl.fbkIdx);
		events  = '0;
		w1c     = '0;
		unique case (s.state)
			gl_pkg::GL_UNLOCKED: begin
				if (!pinIn.unlockReq && doorOk) begin
					next_s.state   = gl_pkg::GL_LOCKING;
					next_s.lockCmd = 1'b1;
					tmrLoad        = 1'b1;
				end
			end
			gl_pkg::GL_LOCKING: begin
				if (pinIn.lockFbk) begin
					next_s.state    = gl_pkg::GL_LOCKED;
					events.lockedEv = 1'b1;
				end else if (tmrDone) begin
					// feedback too late
					next_s.state   = gl_pkg::GL_FAULT;
					next_s.lockCmd = 1'b0;
					events.faultEv = 1'b1;
				end
			end
			gl_pkg::GL_LOCKED: begin
				if (lockFault) begin
					next_s.state   = gl_pkg::GL_FAULT;
					next_s.lockCmd = 1'b0;
					events.faultEv = 1'b1;
				end else if (pinIn.unlockReq) begin
					// only this state listens to the request
					next_s.state = gl_pkg::GL_RELEASE;
					tmrLoad      = 1'b1;
					tmrMs        = gl_pkg::unlockMs(s.ctrl.unlockIdx);
				end
			end
			gl_pkg::GL_RELEASE: begin
				// lock stays driven until the release delay runs out
				if (lockFault) begin
					next_s.state   = gl_pkg::GL_FAULT;
					next_s.lockCmd = 1'b0;
					events.faultEv = 1'b1;
				end else if (tmrDone) begin
					next_s.state   = gl_pkg::GL_UNLOCKING;
					next_s.lockCmd = 1'b0;
					tmrLoad        = 1'b1;
				end
			end
			gl_pkg::GL_UNLOCKING: begin
				if (!pinIn.lockFbk) begin
					events.unlockedEv = 1'b1;
					if (s.ctrl.gateMode == gl_pkg::GATE_MANDATORY) begin
						next_s.state = gl_pkg::GL_OPENWAIT;
					end else begin
						next_s.state = gl_pkg::GL_UNLOCKED;
					end
				end else if (tmrDone) begin
					next_s.state   = gl_pkg::GL_FAULT;
					events.faultEv = 1'b1;
				end
			end
			gl_pkg::GL_OPENWAIT: begin
				// cycle may not relock before the door was really opened
				if (!pinIn.gateFbk) begin
					next_s.state = gl_pkg::GL_UNLOCKED;
				end
			end
			gl_pkg::GL_FAULT: begin
				// leave only with the lock released and a reset gesture
				if (!pinIn.lockFbk && resetAccept) begin
					next_s.state = gl_pkg::GL_UNLOCKED;
				end
			end
		endcase

		// register writes
		if (apbWrite) begin
			unique case (paddr)
				gl_pkg::ADDR_CTRL: begin
					next_s.ctrl = pwdata[14:0];
				end
				gl_pkg::ADDR_INT_ST: begin
					w1c = pwdata[2:0];
				end
				gl_pkg::ADDR_INT_MSK: begin
					next_s.irqMask = pwdata[2:0];
				end
				default: begin
				end
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_s.irqStatus = (s.irqStatus & ~w1c) | events;

		// read data
		if (apbSetup) begin
			unique case (paddr)
				gl_pkg::ADDR_CTRL: begin
					next_s.rdata = {17'h0_0000, s.ctrl};
				end
				gl_pkg::ADDR_STATUS: begin
					next_s.rdata = {24'h00_0000, 1'b0, (s.state == gl_pkg::GL_FAULT),
						pinIn.gateFbk, pinIn.lockFbk, s.lockCmd, pinOut};
				end
				gl_pkg::ADDR_INT_ST: begin
					next_s.rdata = {29'h0000_0000, s.irqStatus};
				end
				gl_pkg::ADDR_INT_MSK: begin
					next_s.rdata = {29'h0000_0000, s.irqMask};
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s.state     <= gl_pkg::GL_UNLOCKED;
			s.lockCmd   <= 1'b0;
			s.ctrl      <= gl_pkg::CTRL_RESET;
			s.irqStatus <= gl_pkg::IRQ_RESET;
			s.irqMask   <= gl_pkg::IRQ_RESET;
			s.rdata     <= 32'h0000_0000;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// combinational so the unlock request and faults drop it the same cycle
	assign pinOut.mainOut   = (s.state == gl_pkg::GL_LOCKED) && !pinIn.unlockReq &&
		!lockFault;
	// spring lock holds with the coil off, so the drive is inverted
	assign pinOut.lockDrive = s.ctrl.spring ? !s.lockCmd : s.lockCmd;
	assign pinOut.faultFlag = s.ctrl.errOutEn && (s.state == gl_pkg::GL_FAULT);
	assign irq              = |(s.irqStatus & s.irqMask);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_main_needs_lock: assert property (
		pinOut.mainOut |-> (pinIn.lockFbk && doorOk && s.lockCmd)
	) else $error("main output high without closed and locked guard");

	a_release_delayed: assert property (
		(s.state == gl_pkg::GL_LOCKED && pinIn.unlockReq && !lockFault)
		|-> !pinOut.mainOut ##1 (s.state == gl_pkg::GL_RELEASE && s.lockCmd)
	) else $error("unlock request did not start the release delay");

	a_unlock_held: assert property (
		(s.state == gl_pkg::GL_RELEASE && !tmrDone && !lockFault)
		|=> (s.state == gl_pkg::GL_RELEASE && s.lockCmd)
	) else $error("lock released before the release delay ran out");

	a_request_ignored: assert property (
		(s.state == gl_pkg::GL_UNLOCKED && pinIn.unlockReq)
		|=> s.state == gl_pkg::GL_UNLOCKED
	) else $error("unlock request acted upon outside locked state");

	a_door_fault: assert property (
		(s.state == gl_pkg::GL_LOCKED && !doorOk)
		|-> !pinOut.mainOut ##1 (s.state == gl_pkg::GL_FAULT && !s.lockCmd)
	) else $error("open door while locked not faulted");

	a_fbk_timeout: assert property (
		(s.state == gl_pkg::GL_LOCKING && tmrDone && !pinIn.lockFbk)
		|=> s.state == gl_pkg::GL_FAULT
	) else $error("late lock feedback not faulted");

	a_mandatory_wait: assert property (
		(s.state == gl_pkg::GL_UNLOCKING && !pinIn.lockFbk &&
		s.ctrl.gateMode == gl_pkg::GATE_MANDATORY)
		|=> (s.state == gl_pkg::GL_OPENWAIT)
	) else $error("mandatory opening mode skipped door confirmation");

	a_gate_ignored: assert property (
		(gateAbsent && s.state == gl_pkg::GL_LOCKED && pinIn.lockFbk &&
		!pinIn.unlockReq) |-> pinOut.mainOut
	) else $error("door feedback used in gate absent mode");

	a_manual_reset: assert property (
		(!s.ctrl.monitored && pinIn.resetIn && !$past(pinIn.resetIn)) |-> resetAccept
	) else $error("manual reset rise not accepted");

	a_monitored_reset: assert property (
		(s.ctrl.monitored && resetAccept) |-> (!pinIn.resetIn && $past(pinIn.resetIn))
	) else $error("monitored reset accepted without rise and fall");

	a_release_short: assert property (
		(s.state == gl_pkg::GL_LOCKED && pinIn.unlockReq && !lockFault &&
		s.ctrl.unlockIdx == 5'h00) |=> ##1 (s.state == gl_pkg::GL_UNLOCKING)
	) else $error("zero release delay not honoured");

	a_error_flag: assert property (
		(s.state == gl_pkg::GL_FAULT && s.ctrl.errOutEn) |-> pinOut.faultFlag
	) else $error("fault flag missing during fault");

	a_error_quiet: assert property (
		pinOut.faultFlag |-> (s.ctrl.errOutEn && s.state == gl_pkg::GL_FAULT)
	) else $error("fault flag raised outside an enabled fault");

	a_spring_drive: assert property (
		(s.ctrl.spring && s.state == gl_pkg::GL_LOCKED) |-> !pinOut.lockDrive
	) else $error("spring lock energised while locked");

	a_fault_sticks: assert property (
		(s.state == gl_pkg::GL_FAULT && !resetAccept) |=> s.state == gl_pkg::GL_FAULT
	) else $error("fault left without accepted reset");

	c_locked: cover property (s.state == gl_pkg::GL_LOCKING ##1 s.state == gl_pkg::GL_LOCKED);
	c_unlock: cover property (s.state == gl_pkg::GL_RELEASE ##[1:8] s.state ==
		gl_pkg::GL_UNLOCKING);
	c_fault_exit: cover property (s.state == gl_pkg::GL_FAULT ##1 s.state ==
		gl_pkg::GL_UNLOCKED);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: tb/gl_lock_model.sv */
// Purpose: behavioural guard lock with coil and bolt feedback
// Assumes: lockDrive changes only after sys_clk edges
// Notes:   stuck pins the feedback low to mimic a jammed bolt
`timescale 1ns/1ns
`default_nettype none
module gl_lock_model (
	// clock
	input  wire logic       sys_clk,
	// coil side
	input  wire logic       lockDrive,
	input  wire logic       spring,
	// behaviour
	input  wire logic [7:0] dlyCyc,
	input  wire logic       stuck,
	// feedback
	output logic            lockFbk
);
	logic [7:0] cnt;
	logic       engage;

	// spring bolt engages with the coil off
	assign engage = spring ? !lockDrive : lockDrive;

	initial begin
		cnt = 8'h00;
		lockFbk = 1'b0;
	end

	// bolt travel takes dlyCyc + 1 cycles, so feedback never follows at once
	always @(posedge sys_clk) begin
		if (stuck || engage == lockFbk) begin
			cnt <= 8'h00;
			if (stuck) begin
				lockFbk <= 1'b0;
			end
		end else if (cnt >= dlyCyc) begin
			cnt <= 8'h00;
			lockFbk <= engage;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: tb/gl_supervisor_tb.sv */
// Purpose: self-checking bench for the guard lock supervisor
// Assumes: 1 ms tick shortened to four cycles
// Notes:   reads are compared by a monitor against a queue of notes
`timescale 1ns/1ns
`default_nettype none
module gl_supervisor_tb;
	localparam int TICK = 4;
	logic                sys_clk, rst_b, psel, penable, pwrite;
	logic                pready, pslverr, irq;
	logic                unlockReq, lockFbk, gateFbk, resetIn;
	logic                spring, stuck;
	logic [7:0]          dlyCyc;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata;
	gl_pkg::gl_pin_in_t  pinIn;
	gl_pkg::gl_pin_out_t pinOut;
	logic [32:0]         expQ[$];
	int                  miscompares, testsRun, n, ms, ix;

	assign pinIn = {unlockReq, lockFbk, gateFbk, resetIn};

	gl_supervisor #(.TICK_CYCLES(TICK)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pinIn(pinIn), .pinOut(pinOut), .irq(irq));

	gl_lock_model u_lock (.sys_clk(sys_clk), .lockDrive(pinOut.lockDrive),
		.spring(spring), .dlyCyc(dlyCyc), .stuck(stuck), .lockFbk(lockFbk));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ------------
	// helpers
	// ------------
	task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		testsRun++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && testsRun > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// idle edge first, so a release never meets a new setup in one step
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			check("apbWait", 1'b0, 1'b1);
			print_verdict();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 32'h0000_0000);
	endtask

	task automatic setPins(input logic u, input logic g, input logic r);
		@(posedge sys_clk);
		unlockReq <= u;
		gateFbk <= g;
		resetIn <= r;
	endtask

	task automatic waitPin(input int b, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (pinOut[b] !== v && cnt < lim) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
	endtask

	task automatic need(input int b, input logic v, input int lim);
		int c;
		waitPin(b, v, lim, c);
		if (c >= lim) begin
			check("pinWait", 1'b0, 1'b1);
			print_verdict();
		end
	endtask

	task automatic gesture(input logic mon);
		waitPin(0, 1'b0, 10, n);
		check("faultHold", n, 10);
		setPins(1'b0, 1'b1, 1'b1);
		if (mon) begin
			waitPin(0, 1'b0, 6, n);
			check("monHold", n, 6);
			setPins(1'b0, 1'b1, 1'b0);
		end
		need(0, 1'b0, 6);
		need(2, 1'b1, 80);
		setPins(1'b0, 1'b1, 1'b0);
	endtask

	function automatic int unlExp(input int i);
		return i < 11 ? i * 100 : i < 29 ? 1500 + (i - 11) * 500 : 15000 + (i - 29) * 5000;
	endfunction

	function automatic int fbkExp(input int i);
		return i < 10 ? (i + 1) * 10 : i < 28 ? 150 + (i - 10) * 50 : 1500 + (i - 28) * 500;
	endfunction

	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expQ.size() == 0) begin
				check("readQueue", 1'b1, 1'b0);
			end else begin
				check("prdata", {pslverr, prdata}, expQ.pop_front());
			end
		end
	end

	// ------------
	// sequence
	// ------------
	initial begin
		miscompares = 0;
		testsRun = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rst_b, unlockReq, resetIn, spring, stuck} = '0;
		gateFbk = 1'b1;
		dlyCyc = 8'h06;
		void'($urandom(32'hae5c_afca));
		repeat (11) @(posedge sys_clk);
		#1 check("rstPins", {irq, pinOut}, 1'b0);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		need(2, 1'b1, 80);
		rd(gl_pkg::ADDR_CTRL, 33'h0_0000_0000);
		rd(gl_pkg::ADDR_STATUS, 33'h0_0000_003E);
		rd(gl_pkg::ADDR_INT_ST, 33'h0_0000_0002);
		rd(12'h010, 33'h1_0000_0000);
		apb(gl_pkg::ADDR_INT_MSK, 1'b1, 32'h0000_0004);
		repeat (2) @(posedge sys_clk);
		check("irqMasked", irq, 1'b0);
		// both ends of the first delay segment and the start of the second, then random picks up to 12
		for (int i = 0; i < 5; i++) begin
			ix = i < 3 ? (i == 0 ? 0 : i + 9) : $urandom % 13;
			apb(gl_pkg::ADDR_CTRL, 1'b1, 32'(ix) << 5);
			// bolt travel must end inside the fault hold and reset gesture
			dlyCyc <= 8'($urandom % 12 + 2);
			setPins(1'b1, 1'b1, 1'b0);
			#1 check("mainDrop", pinOut.mainOut, 1'b0);
			ms = unlExp(ix) * TICK;
			waitPin(1, 1'b0, ms + 8, n);
			check("unlockTime", n >= ms && n <= ms + 4, 1'b1);
			setPins(1'b0, 1'b1, 1'b0);
			need(2, 1'b1, 200);
		end
		check("irqRaised", irq, 1'b1);
		apb(gl_pkg::ADDR_INT_ST, 1'b1, 32'h0000_0007);
		repeat (2) @(posedge sys_clk);
		check("irqCleared", irq, 1'b0);
		// jammed bolt: late feedback, manual then monitored restart
		for (int i = 0; i < 3; i++) begin
			ix = i == 0 ? 28 : (i - 1) * 10;
			apb(gl_pkg::ADDR_CTRL, 1'b1, 32'(ix) << 10 | 32'h0000_0008 | 32'(i[1]) << 2);
			setPins(1'b1, 1'b1, 1'b0);
			need(1, 1'b0, 10);
			repeat (30) @(posedge sys_clk);
			stuck <= 1'b1;
			setPins(1'b0, 1'b1, 1'b0);
			need(1, 1'b1, 4);
			ms = fbkExp(ix) * TICK;
			waitPin(1, 1'b0, ms + 8, n);
			check("fbkTime", n >= ms - 1 && n <= ms + 3, 1'b1);
			check("faultFlag", pinOut.faultFlag, 1'b1);
			stuck <= 1'b0;
			gesture(i[1]);
		end
		setPins(1'b0, 1'b0, 1'b0);
		#1 check("doorOpen", pinOut.mainOut, 1'b0);
		need(0, 1'b1, 4);
		check("coilOff", pinOut.lockDrive, 1'b0);
		setPins(1'b0, 1'b1, 1'b0);
		gesture(1'b1);
		apb(gl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0009);
		setPins(1'b0, 1'b0, 1'b0);
		waitPin(0, 1'b1, 20, n);
		check("gateIgnored", {n == 20, pinOut.mainOut}, 2'b11);
		setPins(1'b0, 1'b1, 1'b0);
		apb(gl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0002);
		setPins(1'b1, 1'b1, 1'b0);
		need(1, 1'b0, 10);
		repeat (30) @(posedge sys_clk);
		setPins(1'b0, 1'b1, 1'b0);
		waitPin(1, 1'b1, 30, n);
		check("openWait", n, 30);
		setPins(1'b0, 1'b0, 1'b0);
		setPins(1'b0, 1'b1, 1'b0);
		need(2, 1'b1, 80);
		// model polarity follows the write in the same edge
		apb(gl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0010);
		spring <= 1'b1;
		repeat (40) @(posedge sys_clk);
		#1 check("springHold", pinOut[2:1], 2'b10);
		setPins(1'b1, 1'b1, 1'b0);
		need(1, 1'b1, 10);
		print_verdict();
	end
endmodule
`default_nettype wire
